// ---- tb_tpg_pattern_gen.sv ----
// self-checking bench for the lane test-pattern generator
module tb_tpg_pattern_gen;
    timeunit 1ns;
    timeprecision 1ns;
    localparam tpg_pkg::tpg_cfg_type C8 = '{4'h8, 1'b0, 1'b0, 5'h01, 10'h004};
    localparam tpg_pkg::tpg_cfg_type STC [4] = '{'{4'h4, 1'b0, 1'b0, 5'h01, 10'h004},
        '{4'h8, 1'b1, 1'b1, 5'h08, 10'h004}, '{4'h6, 1'b0, 1'b1, 5'h02, 10'h004}, '{4'h3, 1'b0, 1'b1, 5'h02, 10'h004}};
    localparam logic [9:0] TAPS [5] = '{10'h0C7, 10'h0A9, 10'h1CF, 10'h257, 10'h39F};
    localparam logic [7:0] RJP [12] = '{8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F,
        8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59};
    logic SYS_CLK = 1'b0;
    logic SRST = 1'b1;
    logic [3:0] sel = 4'h0;
    tpg_pkg::tpg_cfg_type cfg = '0;
    logic ila_done = 1'b0;
    logic ser_rdy = 1'b0;
    logic fs = 1'b0;
    logic mfs = 1'b0;
    logic [127:0] samp = '0;
    logic [127:0] prev_samp = '0;
    logic [127:0] lo, raw;
    logic [15:0] kf, pwr;
    tpg_pkg::tpg_ctrl_type ctrl;
    logic sync_n;
    logic req = 1'b0;
    logic chk_en = 1'b0;
    logic [9:0] taps = 10'h0C7;
    int rx_err;
    int seed = 52363;
    int miscompares = 0;
    int n_checks = 0;

    tpg_pattern_gen dut_u (.SYS_CLK(SYS_CLK), .SRST(SRST), .TEST_PATTERN_SELECT(sel), .LINK_MODE_CONFIG(cfg),
        .ILA_DONE(ila_done), .SERDES_READY(ser_rdy), .FRAME_START(fs), .MFRAME_START(mfs), .SYNC_REQ_N(sync_n),
        .SAMPLE_OCTETS(samp), .LINK_OCTETS(lo), .LINK_K_FLAGS(kf), .LINK_CTRL(ctrl), .RAW_BITS(raw),
        .LANE_POWER(pwr));
    tpg_rx_model rx_u (.clk(SYS_CLK), .chk_en(chk_en), .req(req), .tap_a(taps[9:5]), .tap_b(taps[4:0]),
        .raw(raw[7:0]), .sync_req_n(sync_n), .err_cnt(rx_err));

    initial forever #25 SYS_CLK = ~SYS_CLK;
    ////////////////////////////////////////
    function automatic logic [127:0] om(input logic [3:0] n);
        for (int l = 0; l < 16; l++) om[l*8+:8] = (l % 8 < n) ? 8'hFF : 8'h00;
    endfunction : om
    function automatic logic [15:0] pw(input logic [3:0] n);
        for (int l = 0; l < 16; l++) pw[l] = (l % 8) < n;
    endfunction : pw
    function automatic logic [7:0] stp(input tpg_pkg::tpg_cfg_type c, input int i, input int o, input int fr);
        logic [3:0] nb [2];
        int n;
        if (!c.nprime_12) return (fr % 2) ? 8'(255 - i) : 8'(i);
        for (int h = 0; h < 2; h++) begin
            n = 2 * o + h;
            if (c.frame_octets != 5'h08) nb[h] = 4'(4 * i + n);
            else if (n == 15) nb[h] = 4'h0;
            else nb[h] = (n % 3 == 0) ? 4'(15 - i) : (n % 3 == 1) ? 4'(i) : 4'(n / 3 + 1);
        end
        return {nb[0], nb[1]};
    endfunction : stp
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // outputs seen on return answer the inputs of the previous call
    task automatic cyc(input logic f, input logic m);
        @(posedge SYS_CLK);
        prev_samp = samp;
        fs <= f;
        mfs <= m;
        samp <= {$random(seed), $random(seed), $random(seed), $random(seed)};
        @(negedge SYS_CLK);
    endtask : cyc
    task automatic mode(input logic [3:0] s, input tpg_pkg::tpg_cfg_type c);
        @(posedge SYS_CLK);
        sel <= s;
        cfg <= c;
        repeat (3) cyc(1'b0, 1'b0);
    endtask : mode
    task automatic results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////
    initial begin
        #500000;
        miscompares++;
        results();
    end
    initial begin
        tpg_pkg::tpg_cfg_type c;
        logic [127:0] e;
        logic [3:0] s;
        logic hit;
        repeat (3) @(posedge SYS_CLK);
        @(negedge SYS_CLK);
        chk(lo | raw | pwr, '0);
        @(posedge SYS_CLK);
        SRST <= 1'b0;
        // normal codes and 8b/10b-only codes under 64b/66b, random lane counts
        for (int i = 0; i < 14; i++) begin
            s = (i % 7 == 0) ? 4'h0 : 4'(9 + i % 7);
            c = 21'($random(seed));
            c.lanes_per_link = 4'($unsigned($random(seed)) % 9);
            if (s inside {[4'hA:4'hC]}) c.enc_64b66b = 1'b1;
            mode(s, c);
            cyc(1'b0, 1'b0);
            chk(lo, prev_samp & om(c.lanes_per_link));
            chk(pwr, pw(c.lanes_per_link));
        end
        for (int m = 1; m <= 5; m++) begin
            mode(4'(m), C8);
            taps <= TAPS[m-1];
            chk(raw[7:0] == raw[15:8], 1'b0);
            chk(ctrl.serializer_bypass, 1'b1);
            chk_en <= 1'b1;
            repeat (40) cyc(1'b0, 1'b0);
            chk(rx_err, 0);
            chk_en <= 1'b0;
        end
        mode(4'h6, C8);
        for (int i = 0; i < 6; i++) begin
            e = {16{~raw[7:0]}};
            cyc(1'b0, 1'b0);
            chk(raw, e);
        end
        for (int r = 0; r < 2; r++) begin
            c = r ? '{4'h5, 1'b1, 1'b0, 5'h01, 10'd300} : C8;
            mode(4'h0, c);
            mode(4'h7, c);
            chk(lo, '0);
            chk(ctrl.transport_off, 1'b1);
            chk(ctrl.scramble_off, 1'b0);
            @(posedge SYS_CLK);
            ila_done <= (r == 0);
            ser_rdy <= (r == 1);
            cyc(1'b0, 1'b1);
            for (int t = 0; t < 280; t++) begin
                cyc(1'b0, 1'b0);
                chk(lo, {16{8'(r ? t % 256 : t % 4)}} & om(c.lanes_per_link));
            end
        end
        for (int k = 0; k < 4; k++) begin
            c = STC[k];
            mode(4'h8, c);
            cyc(1'b1, 1'b1);
            for (int t = 1; t <= 4 * c.frame_octets; t++) begin
                cyc(t % c.frame_octets == 0, 1'b0);
                e = '0;
                for (int l = 0; l < 16; l++)
                    if (l % 8 < c.lanes_per_link) e[l*8+:8] = stp(c, l % 8, (t-1) % c.frame_octets, (t-1) / c.frame_octets);
                chk(lo, e);
            end
        end
        mode(4'h9, C8);
        chk(lo, {16{8'hB5}});
        c = C8;
        c.enc_64b66b = 1'b1;
        mode(4'h9, c);
        chk(raw, {16{8'hAA}});
        mode(4'hA, C8);
        chk(lo, {16{8'hBC}});
        chk(kf, 16'hFFFF);
        mode(4'hB, C8);
        chk(ctrl.ila_repeat, 1'b1);
        req <= 1'b1;
        hit = 1'b0;
        repeat (10) begin
            cyc(1'b0, 1'b0);
            hit = hit | (ctrl.cgs_restart === 1'b1);
        end
        chk(hit, 1'b1);
        req <= 1'b0;
        mode(4'hC, C8);
        chk(ctrl.scramble_off, 1'b1);
        for (int i = 0; i < 13 && lo[7:0] !== 8'hBE; i++) cyc(1'b0, 1'b0);
        for (int i = 1; i < 25; i++) begin
            cyc(1'b0, 1'b0);
            chk(lo[7:0], RJP[i % 12]);
        end
        results();
    end
endmodule : tb_tpg_pattern_gen

// ---- tpg_pattern_gen.sv ----
// tpg_pattern_gen: per-lane test-pattern insertion for the serial transmit path
module tpg_pattern_gen #(
    parameter int LANES_PER_LINK = tpg_pkg::LANES_PER_LINK,
    localparam int NL = 2 * LANES_PER_LINK
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic SRST,
    // selection and link configuration
    input wire logic [3:0] TEST_PATTERN_SELECT,
    input wire tpg_pkg::tpg_cfg_type LINK_MODE_CONFIG,
    // link layer status, same clock
    input wire logic ILA_DONE,
    input wire logic SERDES_READY,
    input wire logic FRAME_START,
    input wire logic MFRAME_START,
    // receiver sync request pin, active low, asynchronous
    input wire logic SYNC_REQ_N,
    // formatter octets, lane l in bits l*8+7..l*8
    input wire logic [NL*8-1:0] SAMPLE_OCTETS,
    // toward link layer
    output logic [NL*8-1:0] LINK_OCTETS,
    output logic [NL-1:0] LINK_K_FLAGS,
    output tpg_pkg::tpg_ctrl_type LINK_CTRL,
    // toward serializers
    output logic [NL*8-1:0] RAW_BITS,
    output logic [NL-1:0] LANE_POWER
);

////////////////////////////////////////////////////////////////////////////////
// functions

    function automatic logic needs_8b10b(input logic [3:0] s);
        return s == tpg_pkg::TP_K28_5 || s == tpg_pkg::TP_ILA_RPT || s == tpg_pkg::TP_RJ_PATTERN;
    endfunction : needs_8b10b

    function automatic logic is_prbs(input tpg_pkg::tpg_sel_type s);
        return s >= tpg_pkg::TP_PRBS7 && s <= tpg_pkg::TP_PRBS31;
    endfunction : is_prbs

    function automatic logic [9:0] prbs_taps(input tpg_pkg::tpg_sel_type s);
        case (s)
            tpg_pkg::TP_PRBS9: return {tpg_pkg::PRBS9_TAP_A, tpg_pkg::PRBS9_TAP_B};
            tpg_pkg::TP_PRBS15: return {tpg_pkg::PRBS15_TAP_A, tpg_pkg::PRBS15_TAP_B};
            tpg_pkg::TP_PRBS23: return {tpg_pkg::PRBS23_TAP_A, tpg_pkg::PRBS23_TAP_B};
            tpg_pkg::TP_PRBS31: return {tpg_pkg::PRBS31_TAP_A, tpg_pkg::PRBS31_TAP_B};
            default: return {tpg_pkg::PRBS7_TAP_A, tpg_pkg::PRBS7_TAP_B};
        endcase
    endfunction : prbs_taps

    // bit 0 holds the newest bit, so y[n-k] sits at bit k-1
    function automatic logic [30:0] prbs_step8(input logic [30:0] s, input logic [9:0] taps);
        logic [30:0] v;
        logic [4:0] ta;
        logic [4:0] tb;
        v = s;
        ta = taps[9:5] - 5'h01;
        tb = taps[4:0] - 5'h01;
        for (int i = 0; i < 8; i++) begin
            v = {v[29:0], v[ta] ^ v[tb]};
        end
        return v;
    endfunction : prbs_step8

    // nibble n of lane i for the N'=12 layouts
    function automatic logic [3:0] stp_nibble(input logic f8, input logic [3:0] i, input logic [4:0] n);
        logic [4:0] smp;
        logic [4:0] pos;
        smp = n / 5'h03;
        pos = n % 5'h03;
        if (!f8) begin
            return 4'({i, 2'b00} + n[3:0]);
        end else if (n == tpg_pkg::STP_TAIL_POS) begin
            return tpg_pkg::STP_TAIL;
        end else if (pos == 5'h00) begin
            return tpg_pkg::STP_TOP - i;
        end else if (pos == 5'h01) begin
            return i;
        end else begin
            return 4'(smp + 5'h01);
        end
    endfunction : stp_nibble

    function automatic logic [7:0] stp_octet(
        input tpg_pkg::tpg_cfg_type c,
        input logic [3:0] k,
        input logic [4:0] o,
        input logic odd
    );
        logic f8;
        f8 = c.frame_octets == tpg_pkg::STP_F8;
        if (!c.nprime_12) begin
            return odd ? tpg_pkg::STP_INVERT - {4'h0, k} : {4'h0, k};
        end
        return {stp_nibble(f8, k, {o[3:0], 1'b0}), stp_nibble(f8, k, {o[3:0], 1'b1})};
    endfunction : stp_octet

////////////////////////////////////////////////////////////////////////////////
// mode decode

    tpg_pkg::tpg_cfg_type cfg;
    tpg_pkg::tpg_sel_type mode;
    logic enc8;

    assign cfg = LINK_MODE_CONFIG;
    assign enc8 = !cfg.enc_64b66b;

    // taken live: the selection only moves while the link is down
    always_comb begin
        mode = tpg_pkg::TP_NORMAL;
        if (TEST_PATTERN_SELECT <= tpg_pkg::SEL_LAST) begin
            if (!(needs_8b10b(TEST_PATTERN_SELECT) && !enc8)) begin
                mode = tpg_pkg::tpg_sel_type'(TEST_PATTERN_SELECT);
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// sync request pin

    logic [2:0] sync_q_r;
    logic sync_req_r;
    logic sync_req_d_r;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            sync_q_r <= 3'h7;
        end else begin
            sync_q_r <= {sync_q_r[1:0], SYNC_REQ_N};
        end
    end

    // a level counts once the second and third stage agree
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            sync_req_r <= 1'b0;
            sync_req_d_r <= 1'b0;
        end else begin
            if (sync_q_r[1] == sync_q_r[2]) begin
                sync_req_r <= !sync_q_r[2];
            end
            sync_req_d_r <= sync_req_r;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// frame, multiframe and sequence counters

    logic [4:0] oct_idx_r;
    logic [4:0] oct_idx_nxt;
    logic odd_frame_r;
    logic odd_frame_nxt;
    logic [7:0] ramp_idx_r;
    logic [7:0] ramp_idx_nxt;
    logic ramp_run_r;
    logic [3:0] rjp_idx_r;
    logic clk_phase_r;

    always_comb begin
        oct_idx_nxt = FRAME_START ? 5'h00 : oct_idx_r + 5'h01;
        odd_frame_nxt = FRAME_START ? !odd_frame_r : odd_frame_r;
        if (MFRAME_START) begin
            odd_frame_nxt = 1'b0;
        end
        if (MFRAME_START) begin
            ramp_idx_nxt = 8'h00;
        end else if (cfg.k_frames <= tpg_pkg::RAMP_K_LIMIT
                     && {2'b00, ramp_idx_r} == cfg.k_frames - 10'h001) begin
            ramp_idx_nxt = 8'h00;
        end else begin
            ramp_idx_nxt = ramp_idx_r + 8'h01;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            oct_idx_r <= 5'h00;
            odd_frame_r <= 1'b1;
        end else begin
            oct_idx_r <= oct_idx_nxt;
            odd_frame_r <= odd_frame_nxt;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ramp_run_r <= 1'b0;
            ramp_idx_r <= 8'h00;
        end else if (mode != tpg_pkg::TP_RAMP) begin
            ramp_run_r <= 1'b0;
            ramp_idx_r <= 8'h00;
        end else if (!ramp_run_r) begin
            ramp_run_r <= enc8 ? ILA_DONE : SERDES_READY;
            ramp_idx_r <= 8'h00;
        end else begin
            ramp_idx_r <= ramp_idx_nxt;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST || mode != tpg_pkg::TP_RJ_PATTERN) begin
            rjp_idx_r <= 4'h0;
        end else if (rjp_idx_r == tpg_pkg::RJP_LAST) begin
            rjp_idx_r <= 4'h0;
        end else begin
            rjp_idx_r <= rjp_idx_r + 4'h1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST || mode != tpg_pkg::TP_CLOCK) begin
            clk_phase_r <= 1'b0;
        end else begin
            clk_phase_r <= !clk_phase_r;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// per-lane pattern selection

    logic [30:0] prbs_r [NL];
    logic [30:0] prbs_nxt [NL];
    logic [7:0] oct_nxt [NL];
    logic [7:0] raw_nxt [NL];
    logic k_nxt [NL];
    logic lane_on [NL];
    logic [9:0] taps;

    assign taps = prbs_taps(mode);

    always_comb begin
        for (int l = 0; l < NL; l++) begin
            lane_on[l] = 4'(l % LANES_PER_LINK) < cfg.lanes_per_link;
            prbs_nxt[l] = prbs_step8(prbs_r[l], taps);
            oct_nxt[l] = SAMPLE_OCTETS[l*8 +: 8];
            raw_nxt[l] = 8'h00;
            k_nxt[l] = 1'b0;
            case (mode)
                tpg_pkg::TP_PRBS7, tpg_pkg::TP_PRBS9, tpg_pkg::TP_PRBS15,
                tpg_pkg::TP_PRBS23, tpg_pkg::TP_PRBS31: begin
                    raw_nxt[l] = prbs_nxt[l][7:0];
                end
                tpg_pkg::TP_CLOCK: begin
                    raw_nxt[l] = clk_phase_r ? tpg_pkg::CLOCK_LO : tpg_pkg::CLOCK_HI;
                end
                tpg_pkg::TP_RAMP: begin
                    oct_nxt[l] = ramp_run_r ? ramp_idx_nxt : 8'h00;
                end
                tpg_pkg::TP_SHORT: begin
                    oct_nxt[l] = stp_octet(cfg, 4'(l % LANES_PER_LINK), oct_idx_nxt, odd_frame_nxt);
                end
                tpg_pkg::TP_D21_5: begin
                    oct_nxt[l] = tpg_pkg::D21_5_OCTET;
                    raw_nxt[l] = tpg_pkg::D21_5_RAW;
                end
                tpg_pkg::TP_K28_5: begin
                    oct_nxt[l] = tpg_pkg::K28_5_OCTET;
                    k_nxt[l] = 1'b1;
                end
                tpg_pkg::TP_RJ_PATTERN: begin
                    oct_nxt[l] = tpg_pkg::RJP_OCTETS[rjp_idx_r];
                end
                default: begin
                    oct_nxt[l] = SAMPLE_OCTETS[l*8 +: 8];
                end
            endcase
        end
    end

    // lanes reseed whenever PRBS is off, so each run restarts from its own seed
    always_ff @(posedge SYS_CLK) begin
        for (int l = 0; l < NL; l++) begin
            if (SRST || !is_prbs(mode)) begin
                prbs_r[l] <= tpg_pkg::PRBS_SEED_BASE | 31'(l + 1);
            end else begin
                prbs_r[l] <= prbs_nxt[l];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// registered outputs

    // octets toward the link layer; disabled lanes stay silent
    always_ff @(posedge SYS_CLK) begin
        for (int l = 0; l < NL; l++) begin
            if (SRST || !lane_on[l]) begin
                LINK_OCTETS[l*8 +: 8] <= 8'h00;
            end else begin
                LINK_OCTETS[l*8 +: 8] <= oct_nxt[l];
            end
        end
    end

    // serializer bits; zero except in the PRBS, clock and D21.5 modes (D21.5 drives them under 8b/10b too)
    always_ff @(posedge SYS_CLK) begin
        for (int l = 0; l < NL; l++) begin
            if (SRST || !lane_on[l]) begin
                RAW_BITS[l*8 +: 8] <= 8'h00;
            end else begin
                RAW_BITS[l*8 +: 8] <= raw_nxt[l];
            end
        end
    end

    // control-character flags follow their octets in the same cycle
    always_ff @(posedge SYS_CLK) begin
        for (int l = 0; l < NL; l++) begin
            if (SRST || !lane_on[l]) begin
                LINK_K_FLAGS[l] <= 1'b0;
            end else begin
                LINK_K_FLAGS[l] <= k_nxt[l];
            end
        end
    end

    // power follows the link mode alone, never the pattern
    always_ff @(posedge SYS_CLK) begin
        for (int l = 0; l < NL; l++) begin
            LANE_POWER[l] <= !SRST && lane_on[l];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            LINK_CTRL <= '0;
        end else begin
            LINK_CTRL.transport_off <= mode == tpg_pkg::TP_RAMP;
            LINK_CTRL.serializer_bypass <= is_prbs(mode) || mode == tpg_pkg::TP_CLOCK
                || (mode == tpg_pkg::TP_D21_5 && !enc8);
            LINK_CTRL.scramble_off <= mode == tpg_pkg::TP_D21_5 || mode == tpg_pkg::TP_K28_5
                || mode == tpg_pkg::TP_RJ_PATTERN;
            LINK_CTRL.ila_repeat <= mode == tpg_pkg::TP_ILA_RPT;
            LINK_CTRL.cgs_restart <= mode == tpg_pkg::TP_ILA_RPT && sync_req_r && !sync_req_d_r;
        end
    end

endmodule : tpg_pattern_gen

// ---- tpg_pattern_gen_checker.sv ----
// port-level concurrent checks for the lane test-pattern generator
module tpg_pattern_gen_checker #(
    parameter int LANES_PER_LINK = tpg_pkg::LANES_PER_LINK,
    localparam int NL = 2 * LANES_PER_LINK
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic SRST,
    // watched inputs
    input wire logic [3:0] TEST_PATTERN_SELECT,
    input wire tpg_pkg::tpg_cfg_type LINK_MODE_CONFIG,
    input wire logic ILA_DONE,
    input wire logic SERDES_READY,
    input wire logic FRAME_START,
    input wire logic MFRAME_START,
    input wire logic SYNC_REQ_N,
    input wire logic [NL*8-1:0] SAMPLE_OCTETS,
    // watched outputs
    input wire logic [NL*8-1:0] LINK_OCTETS,
    input wire logic [NL-1:0] LINK_K_FLAGS,
    input wire tpg_pkg::tpg_ctrl_type LINK_CTRL,
    input wire logic [NL*8-1:0] RAW_BITS,
    input wire logic [NL-1:0] LANE_POWER
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SRST);
    logic live_r;
    logic [3:0] sel_r;
    logic enc_r;
    // one-cycle history; live_r keeps checks quiet on the first edge after reset
    always_ff @(posedge SYS_CLK) begin
        live_r <= !SRST;
        sel_r <= TEST_PATTERN_SELECT;
        enc_r <= LINK_MODE_CONFIG.enc_64b66b;
    end
    function automatic logic [NL-1:0] pmask(input logic [3:0] n);
        for (int l = 0; l < NL; l++) pmask[l] = (l % LANES_PER_LINK) < n;
    endfunction : pmask
    function automatic logic [NL*8-1:0] omask(input logic [NL-1:0] p);
        for (int l = 0; l < NL; l++) omask[l*8+:8] = {8{p[l]}};
    endfunction : omask
    ////////////////////////////////////////
    lane_power_a: assert property (live_r |-> LANE_POWER == pmask($past(LINK_MODE_CONFIG.lanes_per_link)))
        else $error("lane power differs from link mode");
    prbs_bypass_a: assert property (live_r && sel_r inside {[4'h1:4'h5]} |-> LINK_CTRL.serializer_bypass)
        else $error("prbs not routed to serializers");
    clock_toggle_a: assert property (live_r && $past(live_r) && sel_r == 4'h6 && $past(sel_r) == 4'h6
        && LANE_POWER[0] |-> RAW_BITS[7:0] == ~$past(RAW_BITS[7:0]) && RAW_BITS[7:0] inside {8'hFF, 8'h00})
        else $error("clock pattern not alternating");
    ramp_transport_a: assert property (live_r && sel_r == 4'h7 |-> LINK_CTRL.transport_off)
        else $error("transport not off in ramp");
    d21_octet_a: assert property (live_r && sel_r == 4'h9 && !enc_r && LANE_POWER[0] |-> LINK_OCTETS[7:0] == 8'hB5)
        else $error("alternating octet missing");
    k28_comma_a: assert property (live_r && sel_r == 4'hA && !enc_r && LANE_POWER[0]
        |-> LINK_K_FLAGS[0] && LINK_OCTETS[7:0] == 8'hBC)
        else $error("comma stream missing");
    normal_pass_a: assert property (live_r && (sel_r == 4'h0 || sel_r > 4'hC || (sel_r >= 4'hA && enc_r))
        |-> LINK_OCTETS == ($past(SAMPLE_OCTETS) & omask(LANE_POWER)))
        else $error("normal stream not passed through");
    off_lanes_quiet_a: assert property (((LINK_OCTETS | RAW_BITS) & ~omask(LANE_POWER)) == '0
        && (LINK_K_FLAGS & ~LANE_POWER) == '0)
        else $error("disabled lane carries data");
    cgs_restart_a: assert property (TEST_PATTERN_SELECT == 4'hB && !LINK_MODE_CONFIG.enc_64b66b
        && $fell(SYNC_REQ_N) |-> ##[1:8] LINK_CTRL.cgs_restart)
        else $error("sync request gave no restart");
    rjp_wrap_a: assert property (live_r && $past(live_r) && sel_r == 4'hC && $past(sel_r) == 4'hC && !enc_r
        && LANE_POWER[0] && $past(LINK_OCTETS[7:0]) == 8'h59 |-> LINK_OCTETS[7:0] == 8'hBE)
        else $error("jitter pattern does not wrap");
    ramp_seen_c: cover property (sel_r == 4'h7 && LINK_OCTETS[7:0] == 8'h03);
    cgs_seen_c: cover property (LINK_CTRL.cgs_restart);
    rjp_seen_c: cover property (sel_r == 4'hC && LINK_OCTETS[7:0] == 8'h59);
endmodule : tpg_pattern_gen_checker

bind tpg_pattern_gen tpg_pattern_gen_checker #(.LANES_PER_LINK(LANES_PER_LINK)) chk_u (.SYS_CLK(SYS_CLK),
    .SRST(SRST), .TEST_PATTERN_SELECT(TEST_PATTERN_SELECT), .LINK_MODE_CONFIG(LINK_MODE_CONFIG),
    .ILA_DONE(ILA_DONE), .SERDES_READY(SERDES_READY), .FRAME_START(FRAME_START), .MFRAME_START(MFRAME_START),
    .SYNC_REQ_N(SYNC_REQ_N), .SAMPLE_OCTETS(SAMPLE_OCTETS), .LINK_OCTETS(LINK_OCTETS),
    .LINK_K_FLAGS(LINK_K_FLAGS), .LINK_CTRL(LINK_CTRL), .RAW_BITS(RAW_BITS), .LANE_POWER(LANE_POWER));

// ---- tpg_pkg.sv ----
// tpg_pkg: constants and types for the serial lane test-pattern generator
// Function
// - select field picks the pattern; lane power and rate follow link mode
// - PRBS goes straight to serializers, unscrambled and unencoded
// - PRBS7 bit is XOR of bits six and seven back, period 127
// - PRBS9/15/23/31 use taps 5,9 / 14,15 / 18,23 / 28,31
// - every lane starts its PRBS from its own distinct seed
// - clock mode repeats eight ones then eight zeros, bypassing both layers
// - ramp keeps link layer, disables transport, ignores formatter data
// - ramp starts after alignment (8b/10b) or serializer init (64b/66b)
// - ramp octets identical on all lanes, encoded and scrambled by link
// - ramp counts from zero per multiframe, to K-1 or wrapping at 0xFF
// - N' of 8 or 12 uses the short transport pattern, restarting per frame
// - N'=8 lane k sends k then 0xFF minus k over two frames
// - N'=12 F=8 lane i sends samples (15-i, i, j) plus tail nibble
// - only enabled lowest lanes transmit pattern entries
// - D21.5 mode sends endless alternating one-zero characters
// - K28.5 mode sends endless comma characters, 8b/10b only
// - repeated alignment mode loops the alignment sequence, no data phase
// - sync request in repeated alignment mode redoes code group sync
// - jitter pattern repeats 12 octets starting BE D7 23 47 6B 8F
// - jitter pattern ends B3 14 5E FB 35 59 before repeating
package tpg_pkg;
    localparam int LANES_PER_LINK = 8;

    typedef enum logic [3:0] {
        TP_NORMAL = 4'h0,
        TP_PRBS7 = 4'h1,
        TP_PRBS9 = 4'h2,
        TP_PRBS15 = 4'h3,
        TP_PRBS23 = 4'h4,
        TP_PRBS31 = 4'h5,
        TP_CLOCK = 4'h6,
        TP_RAMP = 4'h7,
        TP_SHORT = 4'h8,
        TP_D21_5 = 4'h9,
        TP_K28_5 = 4'hA,
        TP_ILA_RPT = 4'hB,
        TP_RJ_PATTERN = 4'hC
    } tpg_sel_type;

    typedef struct packed {
        logic [3:0] lanes_per_link;
        logic enc_64b66b;
        logic nprime_12;
        logic [4:0] frame_octets;
        logic [9:0] k_frames;
    } tpg_cfg_type;

    typedef struct packed {
        logic transport_off;
        logic serializer_bypass;
        logic scramble_off;
        logic ila_repeat;
        logic cgs_restart;
    } tpg_ctrl_type;

    localparam logic [3:0] SEL_LAST = 4'hC;
    localparam logic [4:0] PRBS7_TAP_A = 5'h06;
    localparam logic [4:0] PRBS7_TAP_B = 5'h07;
    localparam logic [4:0] PRBS9_TAP_A = 5'h05;
    localparam logic [4:0] PRBS9_TAP_B = 5'h09;
    localparam logic [4:0] PRBS15_TAP_A = 5'h0E;
    localparam logic [4:0] PRBS15_TAP_B = 5'h0F;
    localparam logic [4:0] PRBS23_TAP_A = 5'h12;
    localparam logic [4:0] PRBS23_TAP_B = 5'h17;
    localparam logic [4:0] PRBS31_TAP_A = 5'h1C;
    localparam logic [4:0] PRBS31_TAP_B = 5'h1F;
    localparam logic [30:0] PRBS_SEED_BASE = 31'h5A5A5A00;
    localparam logic [7:0] CLOCK_HI = 8'hFF;
    localparam logic [7:0] CLOCK_LO = 8'h00;
    localparam logic [7:0] D21_5_OCTET = 8'hB5;
    localparam logic [7:0] D21_5_RAW = 8'hAA;
    localparam logic [7:0] K28_5_OCTET = 8'hBC;
    localparam logic [9:0] RAMP_K_LIMIT = 10'h100;
    localparam logic [7:0] STP_INVERT = 8'hFF;
    localparam logic [3:0] STP_TOP = 4'hF;
    localparam logic [3:0] STP_TAIL = 4'h0;
    localparam logic [4:0] STP_TAIL_POS = 5'h0F;
    localparam logic [4:0] STP_F8 = 5'h08;
    localparam logic [3:0] RJP_LAST = 4'hB;
    localparam logic [7:0] RJP_OCTETS [0:11] = '{
        8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F,
        8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59
    };
endpackage : tpg_pkg

// ---- tpg_rx_model.sv ----
// far-end receiver: self-syncing prbs check on lane 0 and sync request pin
module tpg_rx_model (
    // clock and control
    input wire logic clk,
    input wire logic chk_en,
    input wire logic req,
    input wire logic [4:0] tap_a,
    input wire logic [4:0] tap_b,
    // lane 0 serial bits, bit 7 first
    input wire logic [7:0] raw,
    // results
    output logic sync_req_n,
    output int err_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] hist;
    int fill;
    initial sync_req_n = 1'b1;
    initial err_cnt = 0;
    // the pin is asynchronous to the transmitter, so move it well off the edge
    always @(posedge clk) sync_req_n <= #13 !req;
    // no start phase is assumed: the check arms itself once history is full
    always @(posedge clk) begin
        if (!chk_en) begin
            fill = 0;
            err_cnt = 0;
        end else begin
            for (int b = 7; b >= 0; b--) begin
                if (fill >= 31 && raw[b] !== (hist[tap_a-1] ^ hist[tap_b-1])) err_cnt++;
                hist = {hist[30:0], raw[b]};
                fill++;
            end
        end
    end
endmodule : tpg_rx_model
